// ==== rtl/interrupt_wake_control.sv ====
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module interrupt_wake_control
    import wake_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [7:0] PERIPH_FLAGS,
    input wire logic [2:0] CORE_FLAGS,
    input wire logic [2:0] CORE_ENABLES,
    input wire logic HALT_REQ,
    input wire logic WDOG_CLEAR,
    output logic HALTED,
    output logic HALT_DONE,
    output logic WAKE_VECTOR,
    output logic WAKE_INLINE,
    output logic WDOG_EXPIRED,
    output logic IRQ
);
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] pie_one_q;
    logic [1:0] ctrl_q;
    logic [1:0] pwr_status_q, pwr_status_d;
    logic [7:0] prescale_q, prescale_d;
    logic [15:0] wdog_q, wdog_d;
    logic [3:0] irq_status_q, irq_status_d, irq_mask_q;
    core_state_t state_q, state_d;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic halted_q, halt_done_q, wake_vec_q, wake_inl_q, wexp_q, irq_q;

    // ---------------------------------------------------------------
    // flag capture
    // ---------------------------------------------------------------
    irq_flags_t flags;
    logic [10:0] flags_raw;

    assign flags_raw = {PERIPH_FLAGS, CORE_FLAGS};

    flag_sync #(.WIDTH(11)) u_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .async_in(flags_raw),
        .level_out(flags)
    );

    // ---------------------------------------------------------------
    // per-source pending: one enable bit gates one flag bit
    // ---------------------------------------------------------------
    logic [7:0] periph_hit;
    logic [2:0] core_hit;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_periph
            assign periph_hit[gi] = pie_one_q[gi] & flags.periph[gi];
        end
        // core sources bypass the peripheral gate
        for (gi = 0; gi < 3; gi++) begin : g_core
            assign core_hit[gi] = CORE_ENABLES[gi] & flags.core[gi];
        end
    endgenerate

    // ---------------------------------------------------------------
    // wake condition
    // ---------------------------------------------------------------
    logic periph_pending, core_pending, wake_pending;
    logic global_irq_dispatch_enable, peripheral_irq_gate;

    assign global_irq_dispatch_enable = ctrl_q[CTRL_GIE_BIT];
    assign peripheral_irq_gate = ctrl_q[CTRL_PERIPHERAL_IRQ_GATE_BIT];
    assign periph_pending = peripheral_irq_gate & |periph_hit;
    assign core_pending = |core_hit;
    assign wake_pending = periph_pending | core_pending;

    // ---------------------------------------------------------------
    // halt sequencer
    // ---------------------------------------------------------------
    wake_events_t ev;
    logic take_halt, halt_as_nop, halt_complete, wake_now;
    logic prescale_wrap;

    assign take_halt = (state_q == ST_RUN) & HALT_REQ;
    assign halt_as_nop = take_halt & wake_pending;
    // a wake that shows up while the halt is executing does not abort it
    assign halt_complete = state_q == ST_HALT_EXEC;
    assign wake_now = (state_q == ST_HALTED) & wake_pending;
    assign prescale_wrap = prescale_q == PRESCALE_LAST;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (take_halt && !wake_pending) begin
                    state_d = ST_HALT_EXEC;
                end
            end
            ST_HALT_EXEC: begin
                // completion re-checks flags so a late wake exits at once
                state_d = wake_pending ? ST_RUN : ST_HALTED;
            end
            ST_HALTED: begin
                if (wake_pending) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_RUN;
        endcase
    end

    assign ev.nop = halt_as_nop;
    assign ev.sleep = halt_complete;
    assign ev.wake = wake_now | (halt_complete & wake_pending);
    assign ev.wdog = prescale_wrap & (&wdog_q);

    // ---------------------------------------------------------------
    // watchdog and status
    // ---------------------------------------------------------------
    always_comb begin
        prescale_d = prescale_q + 8'h01;
        wdog_d = prescale_wrap ? wdog_q + 16'h0001 : wdog_q;
        pwr_status_d = pwr_status_q;
        if (halt_complete || WDOG_CLEAR) begin
            prescale_d = PRESCALE_RESET;
            wdog_d = WDOG_RESET;
        end
        if (halt_complete) begin
            pwr_status_d[STAT_TO_BIT] = 1'b1;
            pwr_status_d[STAT_PD_BIT] = 1'b0;
        end
        if (ev.wdog) begin
            pwr_status_d[STAT_TO_BIT] = 1'b0;
        end
        // a no-op halt holds both counters and the power status bits for that cycle
        if (halt_as_nop) begin
            prescale_d = prescale_q;
            wdog_d = wdog_q;
            pwr_status_d = pwr_status_q;
        end
    end

    // ---------------------------------------------------------------
    // APB slave: zero-wait, unmapped reads zero and flag slverr
    // ---------------------------------------------------------------
    logic setup, wr_acc, hit;
    logic [31:0] rd_mux;

    assign setup = PSEL & ~PENABLE;
    assign wr_acc = PSEL & PENABLE & PWRITE & pready_q;
    assign hit = PADDR == OFS_PIE_ONE || PADDR == OFS_CORE_CTRL ||
        PADDR == OFS_PWR_STATUS || PADDR == OFS_WDOG ||
        PADDR == OFS_IRQ_STATUS || PADDR == OFS_IRQ_MASK ||
        PADDR == OFS_CORE_FLAGS;

    // one compare shared by every write strobe
    function automatic logic reg_at(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    logic wr_pie, wr_ctrl, wr_mask, wr_status;

    assign wr_pie = wr_acc & reg_at(PADDR, OFS_PIE_ONE);
    assign wr_ctrl = wr_acc & reg_at(PADDR, OFS_CORE_CTRL);
    assign wr_mask = wr_acc & reg_at(PADDR, OFS_IRQ_MASK);
    assign wr_status = wr_acc & reg_at(PADDR, OFS_IRQ_STATUS);

    logic pready_d, pslverr_d;
    logic [31:0] prdata_d;

    assign pready_d = setup;
    assign pslverr_d = setup & ~hit;
    // writes read back as zero so a stale value never looks like an answer
    assign prdata_d = PWRITE ? 32'h00000000 : rd_mux;

    always_comb begin
        case (PADDR)
            OFS_PIE_ONE: rd_mux = pad8(pie_one_q);
            OFS_CORE_CTRL: rd_mux = pad8({6'h00, ctrl_q});
            // software checks powerdown here after a halt
            OFS_PWR_STATUS: rd_mux = pad8({6'h00, pwr_status_q});
            OFS_WDOG: rd_mux = {8'h00, wdog_q, prescale_q};
            OFS_IRQ_STATUS: rd_mux = pad8({4'h0, irq_status_q});
            OFS_IRQ_MASK: rd_mux = pad8({4'h0, irq_mask_q});
            OFS_CORE_FLAGS: rd_mux = pad8({4'h0, state_q, wake_pending, 1'b0});
            default: rd_mux = 32'h00000000;
        endcase
    end

    logic [3:0] status_clr, status_set;

    assign status_clr = wr_status ? PWDATA[3:0] : 4'h0;
    assign status_set = {ev.wdog, ev.wake, ev.sleep, ev.nop};
    // set wins over a write-one clear in the same cycle
    assign irq_status_d = (irq_status_q & ~status_clr) | status_set;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pie_one_q <= PIE_ONE_RESET;
            ctrl_q <= CTRL_RESET;
            irq_mask_q <= IRQ_RESET;
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            if (setup) begin
                prdata_q <= prdata_d;
            end
            if (wr_pie) begin
                pie_one_q <= PWDATA[7:0];
            end
            if (wr_ctrl) begin
                ctrl_q <= PWDATA[1:0];
            end
            if (wr_mask) begin
                irq_mask_q <= PWDATA[3:0];
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_RUN;
            pwr_status_q <= PWR_STATUS_RESET;
            prescale_q <= PRESCALE_RESET;
            wdog_q <= WDOG_RESET;
            irq_status_q <= IRQ_RESET;
        end else begin
            state_q <= state_d;
            pwr_status_q <= pwr_status_d;
            prescale_q <= prescale_d;
            wdog_q <= wdog_d;
            irq_status_q <= irq_status_d;
        end
    end

    // ---------------------------------------------------------------
    // output next values
    // ---------------------------------------------------------------
    logic halted_d, halt_done_d, wake_vec_d, wake_inl_d, irq_d;

    assign halted_d = state_d != ST_RUN;
    assign halt_done_d = halt_as_nop | halt_complete;
    // dispatch is looked at on the waking cycle, not when the halt began
    assign wake_vec_d = ev.wake & global_irq_dispatch_enable;
    assign wake_inl_d = ev.wake & ~global_irq_dispatch_enable;
    assign irq_d = |(irq_status_d & irq_mask_q);

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            halted_q <= 1'b0;
            halt_done_q <= 1'b0;
            wake_vec_q <= 1'b0;
            wake_inl_q <= 1'b0;
            wexp_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            halted_q <= halted_d;
            halt_done_q <= halt_done_d;
            wake_vec_q <= wake_vec_d;
            wake_inl_q <= wake_inl_d;
            wexp_q <= ev.wdog;
            irq_q <= irq_d;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign HALTED = halted_q;
    assign HALT_DONE = halt_done_q;
    assign WAKE_VECTOR = wake_vec_q;
    assign WAKE_INLINE = wake_inl_q;
    assign WDOG_EXPIRED = wexp_q;
    assign IRQ = irq_q;
endmodule

// ==== rtl/wake_pkg.sv ====
package wake_pkg;

    // ---------------------------------------------------------------
    // register map (byte addresses on APB)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_PIE_ONE = 8'h00;
    localparam logic [7:0] OFS_CORE_CTRL = 8'h04;
    localparam logic [7:0] OFS_PWR_STATUS = 8'h08;
    localparam logic [7:0] OFS_WDOG = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_CORE_FLAGS = 8'h18;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CTRL_GIE_BIT = 1;
    localparam int CTRL_PERIPHERAL_IRQ_GATE_BIT = 0;
    localparam int STAT_TO_BIT = 1;
    localparam int STAT_PD_BIT = 0;
    localparam int EV_NOP_BIT = 0;
    localparam int EV_SLEEP_BIT = 1;
    localparam int EV_WAKE_BIT = 2;
    localparam int EV_WDOG_BIT = 3;

    // ---------------------------------------------------------------
    // reset values and counts
    // ---------------------------------------------------------------
    localparam logic [7:0] PIE_ONE_RESET = 8'h00;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [1:0] PWR_STATUS_RESET = 2'h3;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;
    localparam logic [15:0] WDOG_RESET = 16'h0000;
    localparam logic [7:0] PRESCALE_LAST = 8'hFF;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HALT_EXEC = 2'b01,
        ST_HALTED = 2'b11
    } core_state_t;

    typedef struct packed {
        logic [7:0] periph;
        logic [2:0] core;
    } irq_flags_t;

    typedef struct packed {
        logic nop;
        logic sleep;
        logic wake;
        logic wdog;
    } wake_events_t;

    function automatic logic [31:0] pad8(input logic [7:0] v);
        return {24'h000000, v};
    endfunction

endpackage

// ==== rtl/flag_sync.sv ====
`timescale 1ns/1ps
module flag_sync
    import wake_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_out
);
    // ---------------------------------------------------------------
    // three-stage capture; a change counts once stages two and three agree
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
        end
    end

    assign level_out = lvl_q;
endmodule

// ==== testbench/flag_source.sv ====
`timescale 1ns/1ps
module flag_source
    import wake_pkg::*;
(
    input wire logic clk,
    output irq_flags_t flags
);
    initial flags = '0;

    // flags move just after an edge; the block synchronises them itself
    task automatic drive(input logic [7:0] p, input logic [2:0] c);
        @(posedge clk);
        flags.periph <= p;
        flags.core <= c;
    endtask
endmodule

// ==== testbench/wake_checker.sv ====
`timescale 1ns/1ps
module wake_checker (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic HALTED,
    input wire logic HALT_DONE,
    input wire logic WAKE_VECTOR,
    input wire logic WAKE_INLINE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    sequence s_exec;
        HALTED ##1 HALT_DONE;
    endsequence
    property p_ready_after_setup; PSEL && !PENABLE |=> PREADY; endproperty
    property p_ready_cause; PREADY |-> $past(PSEL && !PENABLE); endproperty
    property p_err_ready; PSLVERR |-> PREADY; endproperty
    property p_err_zero; PSLVERR |-> PRDATA == 32'h00000000; endproperty
    property p_exec; $rose(HALTED) |-> s_exec; endproperty
    property p_wake_exit; WAKE_VECTOR || WAKE_INLINE |-> !HALTED && $past(HALTED); endproperty
    property p_fell_wake; $fell(HALTED) |-> WAKE_VECTOR || WAKE_INLINE; endproperty
    property p_wake_excl; !(WAKE_VECTOR && WAKE_INLINE); endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready missing");
    a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    a_exec: assert property (p_exec) else $error("halt not completed");
    a_wake_exit: assert property (p_wake_exit) else $error("wake not leaving halt");
    a_fell_wake: assert property (p_fell_wake) else $error("halt left without wake");
    a_wake_excl: assert property (p_wake_excl) else $error("two wake kinds");
endmodule

bind interrupt_wake_control wake_checker chk (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .HALTED(HALTED),
    .HALT_DONE(HALT_DONE), .WAKE_VECTOR(WAKE_VECTOR), .WAKE_INLINE(WAKE_INLINE));

// ==== testbench/interrupt_wake_control_tb.sv ====
`timescale 1ns/1ps
module interrupt_wake_control_tb;
    import wake_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic halt_req = 1'b0, pready, pslverr, halted, halt_done, wake_vector, wake_inline;
    logic irq, err, seen, vec;
    logic [7:0] paddr = 8'h00;
    logic [2:0] core_en = 3'h0;
    logic [31:0] pwdata = 32'h00000000, prdata, rd, w1;
    irq_flags_t flags;
    int fail_count = 0, comparisons = 0, cycles = 0;

    flag_source src (.clk(clk), .flags(flags));
    // watchdog clear stays low: a halt is the only clearing path exercised here
    interrupt_wake_control uut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PERIPH_FLAGS(flags.periph), .CORE_FLAGS(flags.core),
        .CORE_ENABLES(core_en), .HALT_REQ(halt_req), .WDOG_CLEAR(1'b0), .HALTED(halted),
        .HALT_DONE(halt_done), .WAKE_VECTOR(wake_vector), .WAKE_INLINE(wake_inline),
        .WDOG_EXPIRED(), .IRQ(irq));

    always #5 clk = ~clk;

    task automatic report_and_stop();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // a one-cycle request: a held level could be taken again after a no-op halt
    task automatic halt();
        seen = 1'b0;
        @(posedge clk);
        halt_req <= 1'b1;
        @(posedge clk);
        halt_req <= 1'b0;
        while (halt_done !== 1'b1) begin
            @(posedge clk);
            if (halted === 1'b1) seen = 1'b1;
        end
    endtask

    task automatic wake();
        while (wake_vector !== 1'b1 && wake_inline !== 1'b1) @(posedge clk);
        vec = wake_vector;
        check(halted, 1'b0);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, OFS_PIE_ONE, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, OFS_PWR_STATUS, 32'h0);
        apb(1'b0, OFS_PWR_STATUS, 32'h0);
        check(rd, 32'h3);
        apb(1'b0, 8'h1C, 32'h0);
        check({rd[30:0], err}, 32'h1);
        // -----------------------------------------------------------
        // pending core source, then each peripheral source, turns the halt into a no-op
        // -----------------------------------------------------------
        core_en <= 3'h1;
        src.drive(8'h00, 3'h1);
        repeat (6) @(posedge clk);
        apb(1'b0, OFS_WDOG, 32'h0);
        w1 = rd;
        halt();
        check(seen, 1'b0);
        apb(1'b0, OFS_WDOG, 32'h0);
        check(rd > w1, 1'b1);
        apb(1'b0, OFS_PWR_STATUS, 32'h0);
        check(rd, 32'h3);
        check(irq, 1'b0);
        apb(1'b1, OFS_IRQ_MASK, 32'hF);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        check(rd, 32'h1);
        check(irq, 1'b1);
        apb(1'b1, OFS_IRQ_STATUS, 32'h1);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        check(rd, 32'h0);
        check(irq, 1'b0);
        core_en <= 3'h0;
        apb(1'b1, OFS_CORE_CTRL, 32'h1);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, OFS_PIE_ONE, 32'h1 << i);
            apb(1'b0, OFS_PIE_ONE, 32'h0);
            check(rd, 32'h1 << i);
            src.drive(8'h01 << i, 3'h0);
            repeat (6) @(posedge clk);
            halt();
            check(seen, 1'b0);
        end
        // -----------------------------------------------------------
        // full halts, woken by the peripheral gate and by a late source
        // -----------------------------------------------------------
        apb(1'b1, OFS_CORE_CTRL, 32'h0);
        halt();
        check(seen, 1'b1);
        apb(1'b0, OFS_PWR_STATUS, 32'h0);
        check(rd, 32'h2);
        apb(1'b0, OFS_WDOG, 32'h0);
        check(rd < 32'h10, 1'b1);
        apb(1'b0, OFS_CORE_FLAGS, 32'h0);
        check(rd, {28'h0, ST_HALTED, 2'b00});
        apb(1'b1, OFS_CORE_CTRL, 32'h3);
        wake();
        check(vec, 1'b1);
        src.drive(8'h00, 3'h0);
        apb(1'b1, OFS_CORE_CTRL, 32'h1);
        repeat (6) @(posedge clk);
        halt();
        check(seen, 1'b1);
        core_en <= 3'h4;
        src.drive(8'h00, 3'h4);
        wake();
        check(vec, 1'b0);
        // -----------------------------------------------------------
        // source enabled while the halt executes: finish, then leave
        // -----------------------------------------------------------
        core_en <= 3'h0;
        @(posedge clk);
        halt_req <= 1'b1;
        @(posedge clk);
        halt_req <= 1'b0;
        core_en <= 3'h4;
        @(posedge clk);
        check(halted, 1'b1);
        check(halt_done, 1'b0);
        @(posedge clk);
        check(halt_done, 1'b1);
        check(wake_inline, 1'b1);
        check(halted, 1'b0);
        apb(1'b0, OFS_PWR_STATUS, 32'h0);
        check(rd, 32'h2);
        report_and_stop();
    end
endmodule
